/* tb/ctrl_model.sv */
// behavioural memory controller driving the device command bus
`timescale 1ns/1ps
module ctrl_model #(
   parameter int START_CYC = 10000,
   parameter int MRD_CYC = 4
) (
   input wire logic ref_clk_i,
   output dram_setup_pkg::cmd_bus_t cmd_o,
   output logic rst_pin_n_o
);
   import dram_setup_pkg::*;
   logic cke_r = 1'b0;
   // ======================================
   // command tasks
   initial begin
      cmd_o = {4'hf, 1'b0, 3'h0, 12'h000};
      rst_pin_n_o = 1'b0;
   end
   task automatic send(input logic [3:0] s, input logic [2:0] ba, input logic [11:0] a);
      @(posedge ref_clk_i);
      cmd_o <= {s, cke_r, ba, a};
   endtask : send
   // released address lines toggle, so a stale value is never trusted
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge ref_clk_i);
         cmd_o <= {4'h7, cke_r, ~cmd_o.ba, ~cmd_o.addr};
      end
   endtask : idle
   task automatic mode_write(input logic [2:0] ba, input logic [11:0] a);
      send(4'h0, ba, a);
      idle(MRD_CYC);
   endtask : mode_write
   // 100 us and 200 us at 50 MHz are 5000 and 10000 cycles
   task automatic pin_cycle(input logic cke_at_rise, input int low_n);
      @(posedge ref_clk_i);
      rst_pin_n_o <= 1'b0;
      cke_r = 1'b0;
      idle(low_n);
      cke_r = cke_at_rise;
      idle(1);
      rst_pin_n_o <= 1'b1;
      cke_r = 1'b1;
      idle(1);
   endtask : pin_cycle
endmodule : ctrl_model

/* tb/testbench.sv */
// self-checking bench for the dram mode setup block
`timescale 1ns/1ps
module testbench;
   import dram_setup_pkg::*;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic beat_ready_i = 1'b0;
   logic hold = 1'b0;
   cmd_bus_t cmd_i;
   logic rst_pin_n_i;
   beat_t beat_o;
   mode_status_t mode_o;
   dev_state_t state_o;
   logic [11:0] ext_mode_o;
   logic beat_valid_o, cmd_refused_o, addr_term_full_o, dq_term_half_o, dq_oe_o;
   logic odt_en_o, dll_on_o, dll_locked_o, zq_update_o, rx_always_on_o, pd_block_o;
   logic pd_violation_o;
   int bad_count = 0;
   int checked = 0;
   beat_t exp_q[$];
   initial forever #10 ref_clk_i = ~ref_clk_i;
   ctrl_model ctrl_u (.ref_clk_i(ref_clk_i), .cmd_o(cmd_i), .rst_pin_n_o(rst_pin_n_i));
   dram_mode_setup #(.DLL_LOCK_CYCLES(20), .FIFO_DEPTH(8)) dut_u (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n_i),
      .cmd_i(cmd_i), .beat_o(beat_o), .beat_valid_o(beat_valid_o),
      .beat_ready_i(beat_ready_i), .cmd_refused_o(cmd_refused_o), .mode_o(mode_o),
      .ext_mode_o(ext_mode_o), .addr_term_full_o(addr_term_full_o),
      .dq_term_half_o(dq_term_half_o), .dq_oe_o(dq_oe_o), .odt_en_o(odt_en_o),
      .dll_on_o(dll_on_o), .dll_locked_o(dll_locked_o), .zq_update_o(zq_update_o),
      .rx_always_on_o(rx_always_on_o), .pd_block_o(pd_block_o),
      .pd_violation_o(pd_violation_o), .state_o(state_o));
   // ======================================
   // checking and reporting
   task automatic report_and_stop();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic timeout();
      bad_count++;
      report_and_stop();
   endtask : timeout
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_beat(input beat_t got, input beat_t exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t beat got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_beat
   function automatic mode_status_t exp_mode(input logic [11:0] a);
      logic [3:0] cl;
      cl = {a[2], a[6:4]};
      return '{a[1:0] == 2'h3, cl, a[11:9], a[7], a[8],
               cl < 4 || cl > 11 || a[11:9] == 3'h0, !a[1], a[3]};
   endfunction : exp_mode
   // consumer stalls at random so the fifo backs up now and then
   always @(posedge ref_clk_i) begin
      beat_ready_i <= !hold && $urandom_range(3) != 0;
      if (!sys_rst_i && beat_valid_o && beat_ready_i) begin
         chk_beat(beat_o, exp_q.size() != 0 ? exp_q.pop_front() : beat_t'('x));
      end
   end
   initial begin
      repeat (40000) @(posedge ref_clk_i);
      timeout();
   end
   task automatic wait_drain();
      int k;
      for (k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge ref_clk_i);
      if (exp_q.size() != 0) timeout();
      ctrl_u.idle(2);
   endtask : wait_drain
   task automatic access(input logic wr, input logic [7:0] a, input int m, input logic b8,
                         input logic dbl);
      int k;
      logic e;
      logic [7:0] c;
      for (k = 0; k < (b8 ? 8 : 4); k++) begin
         c = b8 ? {a[7:3], 3'(a[2:0] + k)} : {a[7:2], 2'(k)};
         exp_q.push_back({wr, c});
      end
      e = !beat_valid_o;
      ctrl_u.send(wr ? 4'h4 : 4'h5, 3'($urandom), {4'($urandom), a});
      if (dbl) begin
         ctrl_u.send(4'h5, 3'($urandom), {4'($urandom), a});
         #1 chk(cmd_refused_o, 1'b1);
      end
      ctrl_u.idle(1);
      #1 chk(zq_update_o, wr);
      k = 0;
      while (e && !beat_valid_o && k < 20) begin
         @(posedge ref_clk_i) #1;
         k++;
      end
      if (k == 20) timeout();
      if (e) chk(k, m + 1 - dbl);
      if (e) chk(dq_oe_o, !wr);
   endtask : access
   // ======================================
   // main sequence
   initial begin
      logic [11:0] a;
      logic [3:0] cl;
      logic [2:0] wl;
      logic [7:0] col;
      logic b8;
      int i, n;
      void'($urandom(32'hafd7));
      @(posedge ref_clk_i) #1 chk(state_o, ST_OFF);
      @(posedge ref_clk_i) sys_rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i) #1;
      chk({dq_oe_o, odt_en_o, dll_on_o}, 3'h0);
      ctrl_u.pin_cycle(1'b0, 10000);
      #1 chk(addr_term_full_o, 1'b0);
      $display("test power_up done");
      ctrl_u.send(4'h2, 3'h0, 12'h400);
      ctrl_u.mode_write(3'h1, 12'h008);
      chk(ext_mode_o, 12'h008);
      chk({dq_term_half_o, dll_on_o, odt_en_o}, 3'h7);
      ctrl_u.send(4'h0, 3'h0, 12'h542);
      n = 0;
      fork
         ctrl_u.idle(14);
         repeat (14) @(posedge ref_clk_i) #1 n += pd_block_o;
      join
      chk(n, 10);
      chk(state_o, ST_LOCK);
      chk(mode_o, exp_mode(12'h542));
      for (n = 0; n < 40 && !dll_locked_o; n++) @(posedge ref_clk_i) #1;
      if (n == 40) timeout();
      chk({mode_o.dll_reset, state_o}, {1'b0, ST_READY});
      ctrl_u.send(4'h2, 3'h0, 12'h400);
      repeat (2) begin
         ctrl_u.send(4'h1, 3'($urandom), 12'($urandom));
         #1 chk(zq_update_o, 1'b1);
      end
      ctrl_u.idle(2);
      $display("test init done");
      for (i = 0; i < 8; i++) begin
         a = 12'($urandom);
         a[8] = 1'b0;
         if (i == 1) a[11:9] = 3'h0;
         if (i == 0) a[3] = 1'b1;
         ctrl_u.mode_write(3'h0, a);
         chk(mode_o, exp_mode(a));
         chk(rx_always_on_o, a[11:9] <= 3'h3);
         ctrl_u.mode_write(3'h1, a & 12'h0bf);
         chk({ext_mode_o, dq_term_half_o, dll_on_o}, {a & 12'h0bf, a[3], 1'b1});
      end
      $display("test decode done");
      // at 50 MHz every read latency is within its frequency limit
      for (i = 0; i < 10; i++) begin
         b8 = 1'($urandom) || i == 1;
         cl = i < 2 ? 4'(4 + 7 * i) : 4'($urandom_range(11, 4));
         wl = 3'($urandom_range(7, 2));
         col = 8'($urandom) & 8'hf8;
         col[2] = b8 && i == 1;
         ctrl_u.mode_write(3'h0, {wl, 2'b00, cl[2:0], 1'b0, cl[3], 1'b1, b8});
         access(i % 3 == 2, col, i % 3 == 2 ? wl : cl, b8, i == 5);
         wait_drain();
      end
      $display("test bursts done");
      hold = 1'b1;
      ctrl_u.mode_write(3'h0, 12'h443);
      access(1'b0, 8'h10, 4, 1'b1, 1'b0);
      ctrl_u.idle(20);
      ctrl_u.mode_write(3'h0, 12'h442);
      access(1'b0, 8'h20, 4, 1'b0, 1'b0);
      ctrl_u.idle(30);
      chk(beat_valid_o, 1'b1);
      hold = 1'b0;
      wait_drain();
      chk(beat_valid_o, 1'b0);
      $display("test fifo done");
      ctrl_u.send(4'h0, 3'h0, 12'h542);
      ctrl_u.idle(3);
      ctrl_u.cke_r = 1'b0;
      ctrl_u.idle(2);
      #1 chk(pd_violation_o, 1'b1);
      fork
         ctrl_u.pin_cycle(1'b1, 8);
         repeat (5) @(posedge ref_clk_i) #1;
      join_any
      chk({dq_oe_o, odt_en_o, dll_on_o}, 3'h0);
      wait fork;
      #1 chk(addr_term_full_o, 1'b1);
      $display("test pin reset done");
      report_and_stop();
   end
endmodule : testbench

/* verilog/burst_fifo.sv */
// small flop fifo carrying burst beats
`timescale 1ns/1ps
module burst_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign in_ready_o = (count_r != (AW+1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_r[rd_ptr_r];

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   AST_FIFO_NO_OVERRUN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      count_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : burst_fifo

/* verilog/dram_mode_setup.sv */
// mode register, init state and burst ordering logic of a graphics dram
// Function
// RULE1: controller holds reset and clock enable low while supplies ramp.
// RULE2: controller waits 100 us of stable power before raising reset.
// RULE3: reset rising edge latches clock enable: 0 half, 1 full address termination.
// RULE4: while reset low, data outputs off, terminators off, dll off.
// RULE5: controller issues no command until 200 us after stable power and clock.
// RULE6: controller sends nop, raises reset and clock enable, then precharges all.
// RULE7: controller then writes extended mode register with bank 01 to enable dll.
// RULE8: controller writes mode register with bank 00, then waits 20K clocks.
// RULE9: controller precharges all and issues at least two auto refreshes.
// RULE10: all four strobes low with clock enable high store address and bank bits.
// RULE11: controller waits mode write recovery time after each mode write.
// RULE12: mode register rewrites allowed only while every bank is idle.
// RULE13: mode register has no reset value; controller programs it after extended write. The block resets it to 12'h000.
// RULE14: fields: burst length, read latency, test mode, dll reset, write latency.
// RULE15: impedance update on every auto refresh and on nop with no read running. The block gives none while in ST_OFF.
// RULE16: data termination selectable between quarter and half reference.
// RULE17: burst runs in aligned block of burst length columns, wrapping inside it.
// RULE18: only sequential ordering; burst type bit must be programmed zero.
// RULE19: burst four: upper bits pick block, low two bits zero, order 0-1-2-3.
// RULE20: burst eight: start 0 gives 0..7, start 4 gives 4..7 then 0..3.
// RULE21: read latency 4 to 11; first data at edge n+m; reserved codes flagged.
// RULE22: controller picks read latency suited to clock frequency and speed grade.
// RULE23: write latency 1 to 7; at 1..3 input receivers stay on.
// RULE24: dll reset bit self clears when lock ends; no power down for 10 clocks.
`timescale 1ns/1ps
`include "dram_setup_params.svh"
module dram_mode_setup #(
   parameter int DLL_LOCK_CYCLES = `DLL_LOCK_CYC,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic rst_pin_n_i,
   input wire dram_setup_pkg::cmd_bus_t cmd_i,
   output dram_setup_pkg::beat_t beat_o,
   output logic beat_valid_o,
   input wire logic beat_ready_i,
   output logic cmd_refused_o,
   output dram_setup_pkg::mode_status_t mode_o,
   output logic [11:0] ext_mode_o,
   output logic addr_term_full_o,
   output logic dq_term_half_o,
   output logic dq_oe_o,
   output logic odt_en_o,
   output logic dll_on_o,
   output logic dll_locked_o,
   output logic zq_update_o,
   output logic rx_always_on_o,
   output logic pd_block_o,
   output logic pd_violation_o,
   output dram_setup_pkg::dev_state_t state_o
);
   import dram_setup_pkg::*;

   // ==========================================================
   // command decode
   cmd_kind_t kind;
   always_comb begin
      kind = CMD_NOP;
      if (cmd_i.cs_n) begin
         kind = CMD_DESEL;
      end else begin
         unique case ({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n})
            3'b000: kind = CMD_MRW;
            3'b001: kind = CMD_REF;
            3'b010: kind = CMD_PRE;
            3'b011: kind = CMD_ACT;
            3'b100: kind = CMD_WR;
            3'b101: kind = CMD_RD;
            3'b110: kind = CMD_NOP;
            3'b111: kind = CMD_NOP;
         endcase
      end
   end

   // ==========================================================
   // reset pin edge and termination latch
   dev_state_t state_r;
   logic rst_pin_q_r;
   logic addr_term_full_r;
   logic pin_rise;
   assign pin_rise = rst_pin_n_i && !rst_pin_q_r;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rst_pin_q_r <= 1'b0;
         addr_term_full_r <= 1'b0;
      end else begin
         rst_pin_q_r <= rst_pin_n_i;
         if (pin_rise) begin
            addr_term_full_r <= cmd_i.cke; // [RULE3]
         end
      end
   end

   // ==========================================================
   // mode register writes
   logic [11:0] mr_r;
   logic [11:0] emr_r;
   logic mrw_hit;
   logic lock_done;
   // mode writes count only with clock enable already high
   assign mrw_hit = (kind == CMD_MRW) && cmd_i.cke && rst_pin_n_i && (state_r != ST_OFF);

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || !rst_pin_n_i) begin
         mr_r <= `MR_RST;
         emr_r <= `EMR_RST;
      end else if (mrw_hit && cmd_i.ba[0]) begin
         emr_r <= cmd_i.addr; // [RULE10]
      end else if (mrw_hit) begin
         mr_r <= cmd_i.addr; // [RULE10]
      end else if (lock_done) begin
         mr_r[`MR_DLLRST_BIT] <= 1'b0; // [RULE24]
      end
   end

   // ==========================================================
   // field decode
   logic [3:0] rl;
   logic [2:0] wl;
   logic burst8;
   assign rl = {mr_r[`MR_CL_HI_BIT], mr_r[`MR_CL_LO_LSB+2:`MR_CL_LO_LSB]}; // [RULE14]
   assign wl = mr_r[`MR_WL_LSB+2:`MR_WL_LSB]; // [RULE14]
   assign burst8 = (mr_r[`MR_BL_LSB+1:`MR_BL_LSB] == `BL_CODE_8);

   always_comb begin
      mode_o.burst8 = burst8;
      mode_o.read_latency = rl;
      mode_o.write_latency = wl;
      mode_o.test_mode = mr_r[`MR_TM_BIT];
      mode_o.dll_reset = mr_r[`MR_DLLRST_BIT];
      mode_o.lat_reserved = (rl < `CL_MIN) || (rl > `CL_MAX) || (wl < `WL_MIN); // [RULE21]
      mode_o.bl_reserved = (mr_r[`MR_BL_LSB+1:`MR_BL_LSB] != `BL_CODE_4) && !burst8;
      mode_o.burst_type_err = mr_r[`MR_BT_BIT]; // [RULE18]
   end
   assign ext_mode_o = emr_r;
   assign rx_always_on_o = (wl <= `RX_ON_WL_MAX); // [RULE23]
   assign dq_term_half_o = emr_r[`EMR_DQ_TERM_BIT]; // [RULE16]
   assign addr_term_full_o = addr_term_full_r;

   // ==========================================================
   // dll lock and power down window
   logic [$clog2(DLL_LOCK_CYCLES+1)-1:0] lock_cnt_r;
   logic [3:0] pd_cnt_r;
   logic dll_rst_cmd;
   assign dll_rst_cmd = mrw_hit && !cmd_i.ba[0] && cmd_i.addr[`MR_DLLRST_BIT];
   assign lock_done = (lock_cnt_r == 1) && !dll_rst_cmd;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || !rst_pin_n_i) begin
         lock_cnt_r <= '0;
      end else if (dll_rst_cmd) begin
         lock_cnt_r <= ($clog2(DLL_LOCK_CYCLES+1))'(DLL_LOCK_CYCLES);
      end else if (lock_cnt_r != '0) begin
         lock_cnt_r <= lock_cnt_r - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pd_cnt_r <= '0;
      end else if (dll_rst_cmd) begin
         pd_cnt_r <= `PD_BLOCK_CYC; // [RULE24]
      end else if (pd_cnt_r != '0) begin
         pd_cnt_r <= pd_cnt_r - 1'b1;
      end
   end

   logic cke_q_r;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cke_q_r <= 1'b0;
         pd_violation_o <= 1'b0;
      end else begin
         cke_q_r <= cmd_i.cke;
         // sticky until sys_rst_i, not cleared by the reset pin, so software never misses it
         if (pd_block_o && cke_q_r && !cmd_i.cke) begin
            pd_violation_o <= 1'b1; // [RULE24]
         end
      end
   end
   assign pd_block_o = (pd_cnt_r != '0);
   assign dll_locked_o = (state_r == ST_READY);

   // ==========================================================
   // device state
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || !rst_pin_n_i) begin
         state_r <= ST_OFF;
      end else begin
         unique case (state_r)
            ST_OFF: state_r <= ST_UNINIT;
            ST_UNINIT: if (dll_rst_cmd) state_r <= ST_LOCK;
            ST_LOCK: if (lock_done) state_r <= ST_READY;
            ST_READY: if (dll_rst_cmd) state_r <= ST_LOCK;
         endcase
      end
   end
   assign state_o = state_r;

   // outputs stay quiet while the reset pin is low
   assign dll_on_o = rst_pin_n_i && !emr_r[`EMR_DLL_OFF_BIT]; // [RULE4]
   assign odt_en_o = rst_pin_n_i && (state_r != ST_OFF); // [RULE4]

   // ==========================================================
   // burst engine: latency then ordered columns
   logic [3:0] lat_cnt_r;
   logic pend_r;
   logic active_r;
   logic wr_r;
   logic [7:0] base_r;
   logic [2:0] beat_r;
   logic [2:0] last_beat;
   logic push_ready;
   logic push;
   logic access;
   beat_t push_beat;

   assign access = ((kind == CMD_RD) || (kind == CMD_WR)) && (state_r == ST_READY);
   assign cmd_refused_o = access && (pend_r || active_r);
   assign last_beat = burst8 ? 3'h7 : 3'h3;
   assign push = active_r;

   always_comb begin
      push_beat.is_write = wr_r;
      if (burst8) begin
         push_beat.col = {base_r[7:3], base_r[2:0] + beat_r}; // [RULE20] [RULE17]
      end else begin
         push_beat.col = {base_r[7:2], beat_r[1:0]}; // [RULE19] [RULE17]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || !rst_pin_n_i) begin
         pend_r <= 1'b0;
         active_r <= 1'b0;
         lat_cnt_r <= '0;
         wr_r <= 1'b0;
         base_r <= '0;
         beat_r <= '0;
      end else if (access && !pend_r && !active_r) begin
         wr_r <= (kind == CMD_WR);
         base_r <= cmd_i.addr[7:0];
         beat_r <= '0;
         // first beat lands on edge n plus latency
         lat_cnt_r <= ((kind == CMD_WR) ? {1'b0, wl} : rl) - 4'h1; // [RULE21] [RULE23]
         pend_r <= 1'b1;
      end else if (pend_r && lat_cnt_r != '0) begin
         lat_cnt_r <= lat_cnt_r - 4'h1;
      end else if (pend_r) begin
         pend_r <= 1'b0;
         active_r <= 1'b1;
      end else if (active_r && push_ready) begin
         // a full buffer stalls beats, so latency is only nominal then
         beat_r <= beat_r + 3'h1;
         if (beat_r == last_beat) begin
            active_r <= 1'b0;
         end
      end
   end
   assign dq_oe_o = rst_pin_n_i && active_r && !wr_r; // [RULE4]

   // outside ST_OFF, impedance refresh fires on refresh commands, and on nop commands only while no read is pending or active
   assign zq_update_o = (state_r != ST_OFF) && ((kind == CMD_REF) ||
      (kind == CMD_NOP && !((pend_r || active_r) && !wr_r))); // [RULE15]

   burst_fifo #(
      .WIDTH($bits(beat_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(push),
      .in_ready_o(push_ready),
      .in_data_i(push_beat),
      .out_valid_o(beat_valid_o),
      .out_ready_i(beat_ready_i),
      .out_data_o(beat_o)
   );

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   AST_TERM_LATCH: assert property (pin_rise |=> addr_term_full_o == $past(cmd_i.cke)) // [RULE3]
      else $error("termination not latched from clock enable");
   AST_QUIET_IN_RESET: assert property (!rst_pin_n_i |-> !dq_oe_o && !odt_en_o && !dll_on_o) // [RULE4]
      else $error("outputs active while reset pin low");
   AST_MRW_STORE: assert property (mrw_hit && !cmd_i.ba[0] |=> mr_r == $past(cmd_i.addr)) // [RULE10]
      else $error("mode write not stored");
   AST_EMRW_STORE: assert property (mrw_hit && cmd_i.ba[0] |=> emr_r == $past(cmd_i.addr)) // [RULE10]
      else $error("extended write not stored");
   AST_RL_FIELD: assert property (mrw_hit && !cmd_i.ba[0] |=> // [RULE14]
      mode_o.read_latency == {$past(cmd_i.addr[2]), $past(cmd_i.addr[6:4])})
      else $error("read latency field misdecoded");
   AST_ZQ_ON_REF: assert property ((kind == CMD_REF) && state_r != ST_OFF |-> zq_update_o) // [RULE15]
      else $error("no impedance update on refresh");
   AST_BL4_ORDER: assert property (push && !burst8 |-> push_beat.col[1:0] == beat_r[1:0]) // [RULE19]
      else $error("burst four order wrong");
   AST_BL8_WRAP: assert property (push && burst8 |-> push_beat.col[7:3] == base_r[7:3]) // [RULE20]
      else $error("burst eight left its block");
   AST_READ_LAT: assert property (access && !pend_r && !active_r && kind == CMD_RD // [RULE21]
      && rl == 4'h4 && !cmd_refused_o |-> ##5 active_r)
      else $error("read latency four not met");
   AST_RX_ON: assert property (wl <= 3'h3 |-> rx_always_on_o) // [RULE23]
      else $error("receivers not held on");
   AST_PD_WINDOW: assert property (dll_rst_cmd |=> pd_block_o [*8]) // [RULE24]
      else $error("power down window too short");

   COV_DLL_RESET: cover property (dll_rst_cmd ##1 state_r == ST_LOCK);
   COV_READY: cover property (state_r == ST_LOCK ##1 state_r == ST_READY);
   COV_BURST8: cover property (push && burst8 && beat_r == 3'h7);
   COV_FULL_STALL: cover property (active_r && !push_ready);
endmodule : dram_mode_setup

/* verilog/dram_setup_params.svh */
// offsets, field positions, reset values and timing counts of the mode setup block
`ifndef DRAM_SETUP_PARAMS_SVH
`define DRAM_SETUP_PARAMS_SVH
// mode register fields
`define MR_BL_LSB 0
`define MR_CL_HI_BIT 2
`define MR_BT_BIT 3
`define MR_CL_LO_LSB 4
`define MR_TM_BIT 7
`define MR_DLLRST_BIT 8
`define MR_WL_LSB 9
// extended mode register fields
`define EMR_DQ_TERM_BIT 3
`define EMR_DLL_OFF_BIT 6
// field codes
`define BL_CODE_4 2'h2
`define BL_CODE_8 2'h3
`define CL_MIN 4'h4
`define CL_MAX 4'hB
`define WL_MIN 3'h1
`define RX_ON_WL_MAX 3'h3
// reset values
`define MR_RST 12'h000
`define EMR_RST 12'h000
// timing counts in clocks and fifo depth in entries
`define DLL_LOCK_CYC 20000
`define PD_BLOCK_CYC 4'hA
`define FIFO_DEPTH 8
`endif

/* verilog/dram_setup_pkg.sv */
// types shared by the mode setup block, its controller model and its testbench
package dram_setup_pkg;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
      logic [2:0] ba;
      logic [11:0] addr;
   } cmd_bus_t;

   typedef struct packed {
      logic is_write;
      logic [7:0] col;
   } beat_t;

   typedef struct packed {
      logic burst8;
      logic [3:0] read_latency;
      logic [2:0] write_latency;
      logic test_mode;
      logic dll_reset;
      logic lat_reserved;
      logic bl_reserved;
      logic burst_type_err;
   } mode_status_t;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_DESEL, CMD_MRW, CMD_REF, CMD_RD, CMD_WR, CMD_PRE, CMD_ACT
   } cmd_kind_t;

   // gray along off -> uninit -> lock -> ready
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_UNINIT = 2'b01,
      ST_LOCK = 2'b11,
      ST_READY = 2'b10
   } dev_state_t;
endpackage : dram_setup_pkg
